// >>> logic/slm_defines.svh
// Constants for the sample-to-lane mapper.
// Assumes it is included by its bare name from the package and the design.
// Contract
// [R1] Mode 2: one octet per lane, lane n carries channel n, 4/2/1 lanes, 8B/10B.
// [R2] Mode 3: five octets per lane, four 9-bit samples each with one zero pad.
// [R3] Mode 4: 9-bit samples padded to 12 bits, packed over 3/2/1 two-octet lanes, 64B/66B.
// [R4] Mode 4: lane 0 then lane 1 split second and third words, zero when absent.
// [R5] Mode 5: two octets per lane, channel pairs per lane, single fills zero.
// [R6] Mode 6: two 12-bit words per channel, three lanes per channel pair, 64B/66B.
// [R7] Mode 7: one octet per lane from its own channel, 4/2/1 lanes, 64B/66B.
// [R8] Mode 8: three octets per lane, two 12-bit words of one channel.
// [R9] Mode 9: 8-bit samples over 8/4/2 lanes with 8B/10B.
// [R10] Mode 10: two lanes per channel, even samples first lane, odd second.
// [R11] Bits go MSB first from octet 0; pads zero; unused lanes disabled.
// [R12] Receiver must use same mode, lanes, encoding and drop pad bits.
`ifndef SLM_DEFINES_SVH
`define SLM_DEFINES_SVH
`define SLM_MAX_LANES 8
`define SLM_MAX_CH    4
`define SLM_MAX_SMP   8
`define SLM_SMP_W     9
`define SLM_FRAME_W   40
`define SLM_MODE_2    4'h2
`define SLM_MODE_3    4'h3
`define SLM_MODE_4    4'h4
`define SLM_MODE_5    4'h5
`define SLM_MODE_6    4'h6
`define SLM_MODE_7    4'h7
`define SLM_MODE_8    4'h8
`define SLM_MODE_9    4'h9
`define SLM_MODE_10   4'ha
`define SLM_PAD1      1'h0
`define SLM_PAD3      3'h0
`define SLM_OCT_1     3'h1
`define SLM_OCT_2     3'h2
`define SLM_OCT_3     3'h3
`define SLM_OCT_5     3'h5
`define SLM_CH_Q      3'h4
`define SLM_CH_D      3'h2
`define SLM_CH_S      3'h1
`define SLM_LN_1      4'h1
`define SLM_LN_2      4'h2
`define SLM_LN_3      4'h3
`define SLM_LN_4      4'h4
`define SLM_LN_6      4'h6
`define SLM_LN_8      4'h8
`endif

// >>> logic/slm_pkg.sv
// Types shared by the sample-to-lane mapper and its bench.
// Assumes slm_defines.svh is on the include path.
`default_nettype none
`include "slm_defines.svh"
package slm_pkg;
  // Device variant: number of converter channels present
  typedef enum logic [1:0] {SLM_QUAD, SLM_DUAL, SLM_SINGLE} slm_var_t;
  // One frame worth of samples: [channel][sample index]
  typedef struct packed {
    logic [`SLM_MAX_CH-1:0][`SLM_MAX_SMP-1:0][`SLM_SMP_W-1:0] smp;
    logic                                                     vld;
  } slm_in_t;
  // Lane frames, left aligned: octet 0 sits in bits [39:32]
  typedef struct packed {
    logic [`SLM_MAX_LANES-1:0][`SLM_FRAME_W-1:0] lane;
    logic [`SLM_MAX_LANES-1:0]                   en;
    logic [3:0]                                  nlanes;
    logic [2:0]                                  octets;
    logic                                        enc66;
    logic                                        err;
    logic                                        vld;
  } slm_out_t;
endpackage : slm_pkg
`default_nettype wire

// >>> logic/slm_lane_mapper.sv
// Maps up to four channels of samples onto up to eight link lanes.
// Assumes one frame of samples per cycle on the frame clock; mode and variant
// are held steady while frames flow.
`timescale 1ns/10ps
`default_nettype none
`include "slm_defines.svh"
module slm_lane_mapper #(
  parameter int unsigned LANES = `SLM_MAX_LANES
) (
  input  wire logic             i_clk,              // Frame clock, 250 MHz
  input  wire logic             i_sys_rst,          // Sync reset, active high
  input  wire logic [3:0]       i_link_mode_select, // Link mode 2..10
  input  wire slm_pkg::slm_var_t i_variant,         // Quad, dual or single
  input  wire slm_pkg::slm_in_t i_frame,            // Samples of one frame
  output var  slm_pkg::slm_out_t o_frame            // Registered lane frames
);
  import slm_pkg::*;

  // Lane array is fixed by the packed output struct
  if (LANES != `SLM_MAX_LANES) begin : g_bad_lanes
    $error("LANES must equal the packed lane count");
  end

  slm_out_t                                     next_frame;
  logic [`SLM_MAX_CH-1:0][`SLM_MAX_SMP-1:0][8:0] s;
  logic [2:0]                                   nch;
  logic [47:0]                                  q;

  function automatic logic [11:0] w12(input logic [8:0] x);
    w12 = {x, `SLM_PAD3};
  endfunction : w12

  function automatic logic [9:0] w10(input logic [8:0] x);
    w10 = {x, `SLM_PAD1};
  endfunction : w10

  // 8-bit modes keep the top eight bits of the sample
  function automatic logic [7:0] o8(input logic [8:0] x);
    o8 = x[8:1];
  endfunction : o8

  // Next lane frames; absent channels are zeroed first so every pad slot
  // and every empty channel slot reads zero without per-mode special cases
  always_comb begin : map
    next_frame = '0;
    q          = '0;
    case (i_variant)
      SLM_QUAD: nch = `SLM_CH_Q;
      SLM_DUAL: nch = `SLM_CH_D;
      default:  nch = `SLM_CH_S;
    endcase
    for (int c = 0; c < `SLM_MAX_CH; c++) begin
      for (int k = 0; k < `SLM_MAX_SMP; k++) begin
        s[c][k] = (3'(c) < nch) ? i_frame.smp[c][k] : '0; // R11
      end
    end
    next_frame.vld = i_frame.vld;
    case (i_link_mode_select)
      `SLM_MODE_2, `SLM_MODE_7: begin
        next_frame.octets = `SLM_OCT_1;
        next_frame.enc66  = (i_link_mode_select == `SLM_MODE_7); // R7
        next_frame.nlanes = 4'(nch);
        for (int c = 0; c < 4; c++) begin
          next_frame.lane[c][39 -: 8] = o8(s[c][0]); // R1 R7
        end
      end
      `SLM_MODE_3: begin
        next_frame.octets = `SLM_OCT_5;
        next_frame.nlanes = 4'(nch);
        for (int c = 0; c < 4; c++) begin
          next_frame.lane[c] = {w10(s[c][0]), w10(s[c][1]),
                                w10(s[c][2]), w10(s[c][3])}; // R2
        end
      end
      `SLM_MODE_4: begin
        next_frame.octets = `SLM_OCT_2;
        next_frame.enc66  = 1'h1;
        next_frame.nlanes = (i_variant == SLM_QUAD) ? `SLM_LN_3 :
                            (i_variant == SLM_DUAL) ? `SLM_LN_2 : `SLM_LN_1;
        // Four words back to back, cut into 16-bit lane frames
        q = {w12(s[0][0]), w12(s[1][0]), w12(s[2][0]), w12(s[3][0])}; // R3 R4
        for (int l = 0; l < 3; l++) begin
          next_frame.lane[l][39 -: 16] = q[47 - 16*l -: 16]; // R3 R4
        end
      end
      `SLM_MODE_5: begin
        next_frame.octets = `SLM_OCT_2;
        next_frame.enc66  = 1'h1;
        next_frame.nlanes = (i_variant == SLM_QUAD) ? `SLM_LN_2 : `SLM_LN_1;
        for (int p = 0; p < 2; p++) begin
          next_frame.lane[p][39 -: 16] = {o8(s[2*p][0]), o8(s[2*p+1][0])}; // R5
        end
      end
      `SLM_MODE_6: begin
        next_frame.octets = `SLM_OCT_2;
        next_frame.enc66  = 1'h1;
        next_frame.nlanes = (i_variant == SLM_QUAD) ? `SLM_LN_6 :
                            (i_variant == SLM_DUAL) ? `SLM_LN_3 : `SLM_LN_2;
        for (int p = 0; p < 2; p++) begin
          q = {w12(s[2*p][0]), w12(s[2*p][1]),
               w12(s[2*p+1][0]), w12(s[2*p+1][1])}; // R6
          for (int l = 0; l < 3; l++) begin
            next_frame.lane[3*p+l][39 -: 16] = q[47 - 16*l -: 16]; // R6
          end
        end
      end
      `SLM_MODE_8: begin
        next_frame.octets = `SLM_OCT_3;
        next_frame.enc66  = 1'h1;
        next_frame.nlanes = 4'(nch);
        for (int c = 0; c < 4; c++) begin
          next_frame.lane[c][39 -: 24] = {w12(s[c][0]), w12(s[c][1])}; // R8
        end
      end
      `SLM_MODE_9: begin
        next_frame.octets = `SLM_OCT_1;
        next_frame.nlanes = (i_variant == SLM_QUAD) ? `SLM_LN_8 :
                            (i_variant == SLM_DUAL) ? `SLM_LN_4 : `SLM_LN_2;
        for (int c = 0; c < 4; c++) begin
          next_frame.lane[2*c][39 -: 8]   = o8(s[c][0]); // R9
          next_frame.lane[2*c+1][39 -: 8] = o8(s[c][1]); // R9
        end
      end
      `SLM_MODE_10: begin
        next_frame.octets = `SLM_OCT_5;
        next_frame.nlanes = (i_variant == SLM_QUAD) ? `SLM_LN_8 :
                            (i_variant == SLM_DUAL) ? `SLM_LN_4 : `SLM_LN_2;
        for (int c = 0; c < 4; c++) begin
          next_frame.lane[2*c]   = {w10(s[c][0]), w10(s[c][2]),
                                    w10(s[c][4]), w10(s[c][6])}; // R10
          next_frame.lane[2*c+1] = {w10(s[c][1]), w10(s[c][3]),
                                    w10(s[c][5]), w10(s[c][7])}; // R10
        end
      end
      default: begin
        // Unsupported mode: every lane stays off rather than send garbage
        next_frame.err = 1'h1;
      end
    endcase
    // Lanes beyond the variant's count are disabled and carry zeros
    for (int l = 0; l < `SLM_MAX_LANES; l++) begin
      next_frame.en[l] = (4'(l) < next_frame.nlanes); // R11
      if (!next_frame.en[l]) begin
        next_frame.lane[l] = '0; // R11
      end
    end
  end

  // Output register; one cycle from sample to lane frame
  always_ff @(posedge i_clk) begin : regs
    if (i_sys_rst) begin
      o_frame <= '0;
    end else begin
      o_frame <= next_frame;
    end
  end

  // Checks of the lane placement, one cycle after the samples
  property p_m2_quad;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_2 && i_variant == SLM_QUAD)
      |=> o_frame.lane[2][39 -: 8] == $past(i_frame.smp[2][0][8:1])
          && o_frame.nlanes == `SLM_LN_4 && !o_frame.enc66;
  endproperty
  a_m2_quad: assert property (p_m2_quad) else $error("mode 2 lane 2 wrong"); // R1

  property p_m3;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_3 && i_variant == SLM_SINGLE)
      |=> o_frame.lane[0][39 -: 10] == {$past(i_frame.smp[0][0]), `SLM_PAD1}
          && o_frame.lane[0][9:0] == {$past(i_frame.smp[0][3]), `SLM_PAD1}
          && o_frame.octets == `SLM_OCT_5;
  endproperty
  a_m3: assert property (p_m3) else $error("mode 3 lane 0 wrong"); // R2

  property p_m4_quad;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_4 && i_variant == SLM_QUAD)
      |=> o_frame.lane[2][39 -: 16] == {$past(i_frame.smp[2][0][0]), `SLM_PAD3,
                                        $past(i_frame.smp[3][0]), `SLM_PAD3}
          && o_frame.enc66 && o_frame.nlanes == `SLM_LN_3;
  endproperty
  a_m4_quad: assert property (p_m4_quad) else $error("mode 4 lane 2 wrong"); // R3

  property p_m4_dual;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_4 && i_variant == SLM_DUAL)
      |=> o_frame.lane[0][27 -: 4] == $past(i_frame.smp[1][0][8:5])
          && o_frame.lane[1][31 -: 8] == '0;
  endproperty
  a_m4_dual: assert property (p_m4_dual) else $error("mode 4 dual split wrong"); // R4

  property p_m5_single;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_5 && i_variant == SLM_SINGLE)
      |=> o_frame.lane[0][31 -: 8] == '0 && o_frame.nlanes == `SLM_LN_1;
  endproperty
  a_m5_single: assert property (p_m5_single) else $error("mode 5 single wrong"); // R5

  property p_m6_single;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_6 && i_variant == SLM_SINGLE)
      |=> o_frame.lane[1][31 -: 8] == '0 && o_frame.nlanes == `SLM_LN_2
          && o_frame.lane[0][27 -: 4] == $past(i_frame.smp[0][1][8:5]);
  endproperty
  a_m6_single: assert property (p_m6_single) else $error("mode 6 single wrong"); // R6

  property p_m7;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_7 && i_variant == SLM_QUAD)
      |=> o_frame.lane[3][39 -: 8] == $past(i_frame.smp[3][0][8:1]) && o_frame.enc66;
  endproperty
  a_m7: assert property (p_m7) else $error("mode 7 lane 3 wrong"); // R7

  property p_m8;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_8 && i_variant != SLM_SINGLE)
      |=> o_frame.lane[1][39 -: 24] == {$past(i_frame.smp[1][0]), `SLM_PAD3,
                                        $past(i_frame.smp[1][1]), `SLM_PAD3};
  endproperty
  a_m8: assert property (p_m8) else $error("mode 8 lane 1 wrong"); // R8

  property p_m9_dual;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_9 && i_variant == SLM_DUAL)
      |=> o_frame.lane[3][39 -: 8] == $past(i_frame.smp[1][1][8:1])
          && o_frame.nlanes == `SLM_LN_4;
  endproperty
  a_m9_dual: assert property (p_m9_dual) else $error("mode 9 lane 3 wrong"); // R9

  property p_m10;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_link_mode_select == `SLM_MODE_10)
      |=> o_frame.lane[1][9:0] == {$past(i_frame.smp[0][7]), `SLM_PAD1}
          && o_frame.lane[0][29 -: 10] == {$past(i_frame.smp[0][2]), `SLM_PAD1};
  endproperty
  a_m10: assert property (p_m10) else $error("mode 10 lane split wrong"); // R10

  property p_lane_off;
    @(posedge i_clk) disable iff (i_sys_rst)
    $countones(o_frame.en) == int'(o_frame.nlanes)
      && (o_frame.en[7] || o_frame.lane[7] == '0);
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("lane enable mismatch"); // R11

endmodule : slm_lane_mapper
`default_nettype wire

// >>> dv/slm_rx_model.sv
// Receiver-side model: recovers the first sample of channel A from lane zero.
// Assumes it is configured with the same link mode as the mapper; it takes no variant.
`timescale 1ns/10ps
`default_nettype none
module slm_rx_model (
  input  wire logic              i_clk,              // Frame clock
  input  wire logic [3:0]        i_link_mode_select, // Link mode, same as the mapper
  input  wire slm_pkg::slm_out_t i_frame,            // Lane frames from the mapper
  output logic [8:0]             o_sample            // Recovered first sample of A
);
  import slm_pkg::*;
  logic [3:0] mode;
  // Configuration follows the mapper one frame later, like its output register
  always_ff @(posedge i_clk) begin
    mode <= i_link_mode_select;
  end
  // Pads dropped; 8-bit modes carry no lsb, so it reads back as zero
  always_comb begin
    o_sample = i_frame.lane[0][39:31];
    if (mode == 4'h2 || mode == 4'h5 || mode == 4'h7 || mode == 4'h9) begin
      o_sample[0] = 1'b0;
    end
  end
endmodule : slm_rx_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the sample-to-lane mapper, random frames per mode.
// Assumes slm_pkg is compiled first; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import slm_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [3:0] mode = 4'h2;
  slm_var_t   vsel = SLM_QUAD;
  slm_in_t    frm = '0;
  slm_out_t   o_frame;
  slm_out_t   expv = '0;
  logic [8:0] rx_smp;
  logic [8:0] exp_rx = 9'h000;
  integer     errors = 0;
  integer     compares = 0;
  integer     seed = 7;
  // Clock at 250 MHz
  always #2 i_clk = ~i_clk;
  slm_lane_mapper #(.LANES(8)) slm_lane_mapper_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_link_mode_select(mode), .i_variant(vsel), .i_frame(frm), .o_frame(o_frame));
  slm_rx_model slm_rx_model_inst (.i_clk(i_clk), .i_link_mode_select(mode),
    .i_frame(o_frame), .o_sample(rx_smp));
  // Reference mapping; inactive channels read as zero, pads are zero
  function automatic slm_out_t exp_map(logic [3:0] m, slm_var_t v, slm_in_t f);
    slm_out_t o;
    logic [3:0][7:0][8:0] s;
    logic [47:0] q;
    int ix;
    o = '0;
    ix = (v == SLM_QUAD) ? 0 : (v == SLM_DUAL) ? 1 : 2;
    for (int c = 0; c < 4; c++) s[c] = (c < (4 >> ix) && c < 4 - ix - (ix > 1)) ? f.smp[c] : '0;
    o.vld = f.vld;
    for (int c = 0; c < 4; c++) begin
      case (m)
        4'h2, 4'h7: o.lane[c][39:32] = s[c][0][8:1];
        4'h3: o.lane[c] = {s[c][0], 1'b0, s[c][1], 1'b0, s[c][2], 1'b0, s[c][3], 1'b0};
        4'h8: o.lane[c][39:16] = {s[c][0], 3'h0, s[c][1], 3'h0};
        4'h9: begin
          o.lane[2*c][39:32] = s[c][0][8:1];
          o.lane[2*c+1][39:32] = s[c][1][8:1];
        end
        4'ha: begin
          o.lane[2*c] = {s[c][0], 1'b0, s[c][2], 1'b0, s[c][4], 1'b0, s[c][6], 1'b0};
          o.lane[2*c+1] = {s[c][1], 1'b0, s[c][3], 1'b0, s[c][5], 1'b0, s[c][7], 1'b0};
        end
        default: ;
      endcase
    end
    if (m == 4'h4) begin
      q = {s[0][0], 3'h0, s[1][0], 3'h0, s[2][0], 3'h0, s[3][0], 3'h0};
      for (int l = 0; l < 3; l++) o.lane[l][39:24] = q[47-16*l -: 16];
    end
    for (int p = 0; p < 2; p++) begin
      if (m == 4'h5) o.lane[p][39:24] = {s[2*p][0][8:1], s[2*p+1][0][8:1]};
      q = {s[2*p][0], 3'h0, s[2*p][1], 3'h0, s[2*p+1][0], 3'h0, s[2*p+1][1], 3'h0};
      for (int l = 0; l < 3; l++) if (m == 4'h6) o.lane[3*p+l][39:24] = q[47-16*l -: 16];
    end
    case (m)
      4'h2, 4'h3, 4'h7, 4'h8: o.nlanes = 4'(4 >> ix);
      4'h4: o.nlanes = 4'(3 - ix);
      4'h5: o.nlanes = (ix == 0) ? 4'h2 : 4'h1;
      4'h6: o.nlanes = (ix == 0) ? 4'h6 : (ix == 1) ? 4'h3 : 4'h2;
      4'h9, 4'ha: o.nlanes = 4'(8 >> ix);
      default: o.err = 1'b1;
    endcase
    o.en = 8'((9'h001 << o.nlanes) - 9'h001);
    o.octets = (m == 4'h3 || m == 4'ha) ? 3'h5 : (m == 4'h8) ? 3'h3 :
               (m >= 4'h4 && m <= 4'h6) ? 3'h2 : o.err ? 3'h0 : 3'h1;
    o.enc66 = (m >= 4'h4 && m <= 4'h8);
    return o;
  endfunction : exp_map
  task automatic chk(input string nm, input slm_out_t e, input slm_out_t g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One frame: check the previous frame's answer, then apply the next inputs
  task automatic step(input logic [3:0] m, input int v, input bit rnd, input bit rst);
    @(negedge i_clk);
    chk("o_frame", expv, o_frame);
    chk("rx_sample", slm_out_t'(exp_rx), slm_out_t'(rx_smp));
    mode = m;
    vsel = slm_var_t'(2'(v));
    // Per-sample fill; corner frames are all ones so any unforced pad bit shows
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 8; k++) frm.smp[c][k] = rnd ? 9'($random(seed)) : 9'h1ff;
    frm.vld = rnd ? 1'($random(seed)) : 1'b1;
    i_sys_rst = rst;
    expv = rst ? '0 : exp_map(m, vsel, frm);
    exp_rx = (rst || expv.err) ? 9'h000 : frm.smp[0][0];
    if (m == 4'h2 || m == 4'h5 || m == 4'h7 || m == 4'h9) exp_rx[0] = 1'b0;
  endtask : step
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Corner cases first: all-ones samples expose any pad bit not forced to zero
  initial begin
    repeat (4) step(4'h2, 0, 1'b0, 1'b1);
    for (int m = 2; m <= 10; m++)
      for (int v = 0; v < 3; v++)
        for (int r = 0; r < 2; r++) step(4'(m), v, r[0], 1'b0);
    step(4'hf, 0, 1'b0, 1'b0);
    step(4'h1, 1, 1'b0, 1'b0);
    repeat (400) step(4'($random(seed)), ($random(seed) & 32'h7fff) % 3, 1'b1,
                      ($random(seed) & 32'h3f) == 0);
    step(4'h2, 0, 1'b1, 1'b0);
    test_done();
  end
  // Watchdog: roughly six and a half times the expected run length
  initial begin
    #12000;
    errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
